// ===== tb/test_anc_cfg_bank.sv
// Self-checking testbench for the auxiliary NCO configuration bank.
`timescale 1ns/1ns
`default_nettype none
`include "anc_map.svh"
module test_anc_cfg_bank;
  import anc_pkg::*;
  // --------------------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------------------
  logic               clk_sys_i = 1'b0;
  logic               rst_i = 1'b1;
  logic [15:0]        avs_address = 16'h0000;
  logic               avs_read = 1'b0;
  logic               avs_write = 1'b0;
  logic [31:0]        avs_writedata = 32'h0000_0000;
  logic [3:0]         avs_byteenable = 4'h0;
  logic [31:0]        avs_readdata;
  logic               avs_waitrequest;
  logic [23:0]        offset_freq_low_i = 24'h000000;
  logic [15:0]        slew_limit_high_i = 16'h0000;
  logic [39:0]        cycle_value_i = 40'h00_0000_0000;
  logic               cycle_apply_i = 1'b0;
  logic [39:0]        phase_delta_i = 40'h00_0000_0000;
  logic               phase_apply_i = 1'b0;
  logic               stamp_i = 1'b0;
  logic [31:0]        offset_freq_o;
  logic [39:0]        time_int_o;
  logic               period_fraction_offset_mode_o;
  logic signed [40:0] phase_target_ps_o;
  logic signed [40:0] phase_target_ui_o;
  logic               slew_enable_o;
  logic [31:0]        slew_limit_o;
  logic               tag_o;
  logic signed [15:0] tag_shift_o;
  logic               tag_shift_valid_o;
  int                 n_errors = 0;
  int                 check_count = 0;
  int                 cycles = 0;
  logic [31:0]        rd;

  anc_cfg_bank u_anc_cfg_bank (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .offset_freq_low_i(offset_freq_low_i), .slew_limit_high_i(slew_limit_high_i),
    .cycle_value_i(cycle_value_i), .cycle_apply_i(cycle_apply_i),
    .phase_delta_i(phase_delta_i), .phase_apply_i(phase_apply_i), .stamp_i(stamp_i),
    .offset_freq_o(offset_freq_o), .time_int_o(time_int_o),
    .period_fraction_offset_mode_o(period_fraction_offset_mode_o),
    .phase_target_ps_o(phase_target_ps_o), .phase_target_ui_o(phase_target_ui_o),
    .slew_enable_o(slew_enable_o), .slew_limit_o(slew_limit_o), .tag_o(tag_o),
    .tag_shift_o(tag_shift_o), .tag_shift_valid_o(tag_shift_valid_o)
  );

  always #50 clk_sys_i = ~clk_sys_i;

  // --------------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // The whole run needs well under a thousand cycles; the ceiling leaves margin.
  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors = n_errors + 1;
      $display("wrong value at %0t: run timed out", $time);
      finish_test();
    end
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
    check_count = check_count + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // Holds the request until waitrequest is sampled low at a rising edge.
  task automatic bus_cycle(input logic wr, input logic [15:0] a, input logic [7:0] d,
                           input logic [3:0] be);
    @(posedge clk_sys_i);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= ~wr;
    do @(posedge clk_sys_i); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wr8(input logic [15:0] a, input logic [7:0] d);
    bus_cycle(1'b1, a, d, 4'h1);
  endtask

  task automatic rd_check(input logic [15:0] a, input logic [7:0] exp);
    bus_cycle(1'b0, a, 8'h00, 4'hf);
    check(rd, {56'h0, exp}, "register read");
  endtask

  // Raises a one-cycle pulse on the given strobe, then lets the result settle.
  task automatic pulse(input int which);
    @(posedge clk_sys_i);
    if (which == 0) stamp_i <= 1'b1;
    if (which == 1) cycle_apply_i <= 1'b1;
    if (which == 2) phase_apply_i <= 1'b1;
    @(posedge clk_sys_i);
    stamp_i <= 1'b0;
    cycle_apply_i <= 1'b0;
    phase_apply_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task automatic test_reset_and_map();
    for (int a = 16'h280a; a <= 16'h2811; a++) rd_check(a[15:0], `ANC_RST_BYTE);
    rd_check(16'h2812, 8'h00);
    wr8(16'h2812, 8'h5a);
    rd_check(16'h2812, 8'h00);
    wr8(`ANC_IDX_ADJUST_MODE, 8'hff);
    rd_check(`ANC_IDX_ADJUST_MODE, 8'h03);
    bus_cycle(1'b1, `ANC_IDX_OFFSET_FREQ_B3, 8'h77, 4'he);
    rd_check(`ANC_IDX_OFFSET_FREQ_B3, 8'h00);
    wr8(`ANC_IDX_ADJUST_MODE, 8'h00);
    $display("test reset and map done");
  endtask

  task automatic test_offset_and_slew();
    offset_freq_low_i <= 24'h345678;
    slew_limit_high_i <= 16'h0000;
    wr8(`ANC_IDX_OFFSET_FREQ_B3, 8'h01);
    rd_check(`ANC_IDX_OFFSET_FREQ_B3, 8'h01);
    check(offset_freq_o, 64'h0000_0000_0134_5678, "offset freq");
    check(slew_enable_o, 64'h0, "slew off at zero");
    wr8(`ANC_IDX_SLEW_LIMIT_B0, 8'h6f);
    wr8(`ANC_IDX_SLEW_LIMIT_B1, 8'h0c);
    slew_limit_high_i <= 16'h0001;
    rd_check(`ANC_IDX_SLEW_LIMIT_B1, 8'h0c);
    check(slew_limit_o, 64'h0000_0000_0001_0c6f, "slew limit");
    check(slew_enable_o, 64'h1, "slew on");
    wr8(`ANC_IDX_SLEW_LIMIT_B0, 8'h00);
    wr8(`ANC_IDX_SLEW_LIMIT_B1, 8'h00);
    slew_limit_high_i <= 16'h0000;
    @(posedge clk_sys_i);
    check(slew_enable_o, 64'h0, "slew off again");
    $display("test offset and slew done");
  endtask

  task automatic test_tags();
    for (int i = 0; i < 4; i++) begin
      pulse(0);
      check(tag_o, 64'h0, "tag while ratio zero");
    end
    wr8(`ANC_IDX_TAG_SHIFT_LO, 8'hfe);
    wr8(`ANC_IDX_TAG_SHIFT_HI, 8'hff);
    @(posedge clk_sys_i);
    check(tag_shift_o, 64'hffff_ffff_ffff_fffe, "tag shift");
    wr8(`ANC_IDX_TAG_SPACING_LO, 8'h02);
    wr8(`ANC_IDX_TAG_SPACING_HI, 8'h00);
    rd_check(`ANC_IDX_TAG_SPACING_LO, 8'h02);
    for (int i = 1; i <= 6; i++) begin
      pulse(0);
      check(tag_o, (i % 3 == 0) ? 64'h1 : 64'h0, "tag pulse");
      if (i == 3) begin
        @(posedge clk_sys_i);
        check(tag_shift_valid_o, 64'h1, "tag shift used");
      end
    end
    rd_check(`ANC_IDX_TAG_SHIFT_LO, 8'h00);
    rd_check(`ANC_IDX_TAG_SHIFT_HI, 8'h00);
    check(tag_shift_o, 64'h0, "tag shift cleared");
    $display("test tags done");
  endtask

  task automatic test_cycle_and_phase();
    cycle_value_i <= 40'h12_3456_789a;
    pulse(1);
    check(time_int_o, 64'h12_3456_789a, "absolute cycle");
    wr8(`ANC_IDX_ADJUST_MODE, 8'h02);
    cycle_value_i <= 40'hff_ffff_fffb;
    pulse(1);
    check(time_int_o, 64'h12_3456_7895, "relative cycle");
    wr8(`ANC_IDX_ADJUST_MODE, 8'h00);
    @(posedge clk_sys_i);
    check(period_fraction_offset_mode_o, 64'h0, "mode ps");
    phase_delta_i <= 40'hff_ffff_ff00;
    pulse(2);
    check(phase_target_ps_o, 64'hffff_ffff_ffff_ff00, "ps target");
    check(phase_target_ui_o, 64'h0, "ui target held");
    wr8(`ANC_IDX_ADJUST_MODE, 8'h01);
    @(posedge clk_sys_i);
    check(period_fraction_offset_mode_o, 64'h1, "mode ui");
    phase_delta_i <= 40'h00_0000_1000;
    pulse(2);
    check(phase_target_ui_o, 64'h1000, "ui target");
    check(phase_target_ps_o, 64'hffff_ffff_ffff_ff00, "ps target held");
    $display("test cycle and phase done");
  endtask

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    test_reset_and_map();
    test_offset_and_slew();
    test_tags();
    test_cycle_and_phase();
    finish_test();
  end
endmodule
`default_nettype wire

// ===== verilog/anc_cfg_bank.sv
// Configuration register bank of the auxiliary time-stamp NCO over Avalon-MM.
//
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "anc_map.svh"
module anc_cfg_bank #(
  parameter int CYC_W = 40
) (
  input  wire logic                clk_sys_i,
  input  wire logic                rst_i,
  // Avalon-MM slave, one word per register, byte data in bits 7:0.
  input  wire logic [15:0]         avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  input  wire logic [3:0]          avs_byteenable,
  output logic [31:0]              avs_readdata,
  output logic                     avs_waitrequest,
  // Neighbouring bytes owned elsewhere in the NCO, then cycle, phase and stamp inputs.
  input  wire logic [23:0]         offset_freq_low_i,
  input  wire logic [15:0]         slew_limit_high_i,
  input  wire logic [CYC_W-1:0]    cycle_value_i,
  input  wire logic                cycle_apply_i,
  input  wire logic [CYC_W-1:0]    phase_delta_i,
  input  wire logic                phase_apply_i,
  input  wire logic                stamp_i,
  // Decoded controls toward the NCO core.
  output logic [31:0]              offset_freq_o,
  output logic [CYC_W-1:0]         time_int_o,
  output logic                     period_fraction_offset_mode_o,
  output logic signed [CYC_W:0]    phase_target_ps_o,
  output logic signed [CYC_W:0]    phase_target_ui_o,
  output logic                     slew_enable_o,
  output logic [31:0]              slew_limit_o,
  output logic                     tag_o,
  output logic signed [15:0]       tag_shift_o,
  output logic                     tag_shift_valid_o
);
  import anc_pkg::*;

  // --------------------------------------------------------------------------
  // Register storage
  // --------------------------------------------------------------------------
  logic [7:0]         offs_b3;
  logic [7:0]         spacing_lo;
  logic [7:0]         spacing_hi;
  logic [7:0]         shift_lo;
  logic [7:0]         shift_hi;
  logic [1:0]         adj_mode;
  logic [7:0]         slew_b0;
  logic [7:0]         slew_b1;
  logic               wait_q;
  logic [31:0]        rdata;
  logic [CYC_W-1:0]   time_int;
  logic signed [CYC_W:0] phase_ps;
  logic signed [CYC_W:0] phase_ui;
  logic               shift_valid;

  logic [7:0]         next_offs_b3;
  logic [7:0]         next_spacing_lo;
  logic [7:0]         next_spacing_hi;
  logic [7:0]         next_shift_lo;
  logic [7:0]         next_shift_hi;
  logic [1:0]         next_adj_mode;
  logic [7:0]         next_slew_b0;
  logic [7:0]         next_slew_b1;
  logic               next_wait_q;
  logic [31:0]        next_rdata;
  logic [CYC_W-1:0]   next_time_int;
  logic signed [CYC_W:0] next_phase_ps;
  logic signed [CYC_W:0] next_phase_ui;
  logic               next_shift_valid;

  logic               wr_acc;
  logic               rd_acc;
  logic               tag_raw;
  logic [7:0]         wbyte;

  function automatic logic hit(input logic [15:0] a, input logic [15:0] idx);
    return a == idx;
  endfunction

  // --------------------------------------------------------------------------
  // Bus handshake
  // --------------------------------------------------------------------------
  // Each access waits exactly one cycle so read data comes from a flop.
  assign avs_waitrequest = (avs_read | avs_write) & ~wait_q;
  assign wr_acc          = avs_write & wait_q;
  assign rd_acc          = avs_read & ~wait_q;
  assign wbyte           = avs_byteenable[0] ? avs_writedata[7:0] : 8'h00;

  // --------------------------------------------------------------------------
  // Register update and NCO controls
  // --------------------------------------------------------------------------
  always_comb begin
    next_offs_b3     = offs_b3;
    next_spacing_lo  = spacing_lo;
    next_spacing_hi  = spacing_hi;
    next_shift_lo    = shift_lo;
    next_shift_hi    = shift_hi;
    next_adj_mode    = adj_mode;
    next_slew_b0     = slew_b0;
    next_slew_b1     = slew_b1;
    next_wait_q      = (avs_read | avs_write) & ~wait_q;
    next_rdata       = rdata;
    next_time_int    = time_int;
    next_phase_ps    = phase_ps;
    next_phase_ui    = phase_ui;
    next_shift_valid = 1'b0;
    // The tag delta clears once the next tagged stamp has taken it.
    if (tag_raw && {shift_hi, shift_lo} != 16'h0000) begin
      next_shift_valid = 1'b1;
      next_shift_lo    = 8'h00;
      next_shift_hi    = 8'h00;
    end
    // A write in the clearing cycle wins, so new software data is kept.
    if (wr_acc && avs_byteenable[0]) begin
      if (hit(avs_address, `ANC_IDX_OFFSET_FREQ_B3)) begin
        next_offs_b3 = wbyte;
      end else if (hit(avs_address, `ANC_IDX_TAG_SPACING_LO)) begin
        next_spacing_lo = wbyte;
      end else if (hit(avs_address, `ANC_IDX_TAG_SPACING_HI)) begin
        next_spacing_hi = wbyte;
      end else if (hit(avs_address, `ANC_IDX_TAG_SHIFT_LO)) begin
        next_shift_lo = wbyte;
      end else if (hit(avs_address, `ANC_IDX_TAG_SHIFT_HI)) begin
        next_shift_hi = wbyte;
      end else if (hit(avs_address, `ANC_IDX_ADJUST_MODE)) begin
        next_adj_mode = wbyte[1:0];
      end else if (hit(avs_address, `ANC_IDX_SLEW_LIMIT_B0)) begin
        next_slew_b0 = wbyte;
      end else if (hit(avs_address, `ANC_IDX_SLEW_LIMIT_B1)) begin
        next_slew_b1 = wbyte;
      end
    end
    if (rd_acc) begin
      if (hit(avs_address, `ANC_IDX_OFFSET_FREQ_B3)) begin
        next_rdata = {24'h000000, offs_b3};
      end else if (hit(avs_address, `ANC_IDX_TAG_SPACING_LO)) begin
        next_rdata = {24'h000000, spacing_lo};
      end else if (hit(avs_address, `ANC_IDX_TAG_SPACING_HI)) begin
        next_rdata = {24'h000000, spacing_hi};
      end else if (hit(avs_address, `ANC_IDX_TAG_SHIFT_LO)) begin
        next_rdata = {24'h000000, shift_lo};
      end else if (hit(avs_address, `ANC_IDX_TAG_SHIFT_HI)) begin
        next_rdata = {24'h000000, shift_hi};
      end else if (hit(avs_address, `ANC_IDX_ADJUST_MODE)) begin
        next_rdata = {30'h0, adj_mode};
      end else if (hit(avs_address, `ANC_IDX_SLEW_LIMIT_B0)) begin
        next_rdata = {24'h000000, slew_b0};
      end else if (hit(avs_address, `ANC_IDX_SLEW_LIMIT_B1)) begin
        next_rdata = {24'h000000, slew_b1};
      end else begin
        next_rdata = `ANC_READ_UNMAPPED;
      end
    end
    if (cycle_apply_i) begin
      if (adj_mode[`ANC_BIT_CYCLE_TYPE]) begin
        next_time_int = time_int + cycle_value_i;
      end else begin
        next_time_int = cycle_value_i;
      end
    end
    // Both unit views are kept signed with one guard bit against overflow.
    if (phase_apply_i) begin
      if (adj_mode[`ANC_BIT_DELTA_TYPE]) begin
        next_phase_ui = $signed({phase_delta_i[CYC_W-1], phase_delta_i});
      end else begin
        next_phase_ps = $signed({phase_delta_i[CYC_W-1], phase_delta_i});
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      offs_b3     <= `ANC_RST_BYTE;
      spacing_lo  <= `ANC_RST_BYTE;
      spacing_hi  <= `ANC_RST_BYTE;
      shift_lo    <= `ANC_RST_BYTE;
      shift_hi    <= `ANC_RST_BYTE;
      adj_mode    <= 2'h0;
      slew_b0     <= `ANC_RST_BYTE;
      slew_b1     <= `ANC_RST_BYTE;
      wait_q      <= 1'b0;
      rdata       <= 32'h0000_0000;
      time_int    <= '0;
      phase_ps    <= '0;
      phase_ui    <= '0;
      shift_valid <= 1'b0;
    end else begin
      offs_b3     <= next_offs_b3;
      spacing_lo  <= next_spacing_lo;
      spacing_hi  <= next_spacing_hi;
      shift_lo    <= next_shift_lo;
      shift_hi    <= next_shift_hi;
      adj_mode    <= next_adj_mode;
      slew_b0     <= next_slew_b0;
      slew_b1     <= next_slew_b1;
      wait_q      <= next_wait_q;
      rdata       <= next_rdata;
      time_int    <= next_time_int;
      phase_ps    <= next_phase_ps;
      phase_ui    <= next_phase_ui;
      shift_valid <= next_shift_valid;
    end
  end

  // --------------------------------------------------------------------------
  // Tag generator
  // --------------------------------------------------------------------------
  anc_tag_gen #(
    .RW(16)
  ) u_anc_tag_gen (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .ratio_i   ({spacing_hi, spacing_lo}),
    .stamp_i   (stamp_i),
    .tag_o     (tag_raw)
  );

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  // Integer byte on top, so one LSB weighs two to minus 24 Hz.
  assign offset_freq_o = {offs_b3, offset_freq_low_i};
  assign slew_limit_o  = {slew_limit_high_i, slew_b1, slew_b0};
  assign slew_enable_o = (slew_limit_o != 32'h0000_0000);
  assign period_fraction_offset_mode_o = adj_mode[`ANC_BIT_DELTA_TYPE];
  assign time_int_o        = time_int;
  assign phase_target_ps_o = phase_ps;
  assign phase_target_ui_o = phase_ui;
  assign avs_readdata      = rdata;
  assign tag_o             = tag_raw;
  assign tag_shift_o       = $signed({shift_hi, shift_lo});
  assign tag_shift_valid_o = shift_valid;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  tag_autoclear_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (tag_raw && {shift_hi, shift_lo} != 16'h0000 && !wr_acc)
      |=> (shift_valid && {shift_hi, shift_lo} == 16'h0000))
    else $error("Tag delta did not self-clear.");
  cycle_abs_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (cycle_apply_i && !adj_mode[`ANC_BIT_CYCLE_TYPE])
      |=> time_int == $past(cycle_value_i))
    else $error("Absolute cycle load wrong.");
  cycle_rel_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (cycle_apply_i && adj_mode[`ANC_BIT_CYCLE_TYPE])
      |=> time_int == CYC_W'($past(time_int) + $past(cycle_value_i)))
    else $error("Relative cycle add wrong.");
  delta_ps_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (phase_apply_i && !adj_mode[`ANC_BIT_DELTA_TYPE])
      |=> (phase_ps[CYC_W-1:0] == $past(phase_delta_i) && $stable(phase_ui)))
    else $error("Picosecond delta not taken.");
  period_fraction_offset_mode_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (phase_apply_i && adj_mode[`ANC_BIT_DELTA_TYPE])
      |=> (phase_ui[CYC_W-1:0] == $past(phase_delta_i) && $stable(phase_ps)))
    else $error("Unit interval delta not taken.");
  delta_sign_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    phase_ui[CYC_W] == phase_ui[CYC_W-1] && phase_ps[CYC_W] == phase_ps[CYC_W-1])
    else $error("Phase delta sign not extended.");
  slew_off_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (slew_b0 == 8'h00 && slew_b1 == 8'h00 && slew_limit_high_i == 16'h0000)
      |-> !slew_enable_o)
    else $error("Slew limiting on with zero limit.");
  slew_write_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (wr_acc && avs_byteenable[0] && avs_address == `ANC_IDX_SLEW_LIMIT_B0)
      |=> slew_limit_o[7:0] == $past(avs_writedata[7:0]))
    else $error("Slew limit byte not stored.");
  offs_write_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (wr_acc && avs_byteenable[0] && avs_address == `ANC_IDX_OFFSET_FREQ_B3)
      |=> offset_freq_o[31:24] == $past(avs_writedata[7:0]))
    else $error("Offset integer byte not stored.");
  mode_read_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (rd_acc && avs_address == `ANC_IDX_ADJUST_MODE)
      |=> (!avs_waitrequest && avs_readdata[31:2] == 30'h0))
    else $error("Adjust register reserved bits not zero.");
  // A held request must see exactly one wait cycle, or a master could stall forever.
  wait_once_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    avs_waitrequest |=> !avs_waitrequest)
    else $error("Bus request waited more than one cycle.");
  spacing_write_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (wr_acc && avs_byteenable[0] && avs_address == `ANC_IDX_TAG_SPACING_LO)
      |=> spacing_lo == $past(avs_writedata[7:0]))
    else $error("Tag spacing byte not stored.");
endmodule
`default_nettype wire

// ===== verilog/anc_map.svh
// Register offsets, field positions and reset values of the auxiliary NCO configuration bank.
`ifndef ANC_MAP_SVH
`define ANC_MAP_SVH

// ----------------------------------------------------------------------------
// Register word addresses, one byte register per word
// ----------------------------------------------------------------------------
`define ANC_IDX_OFFSET_FREQ_B3  16'h280a
`define ANC_IDX_TAG_SPACING_LO  16'h280b
`define ANC_IDX_TAG_SPACING_HI  16'h280c
`define ANC_IDX_TAG_SHIFT_LO    16'h280d
`define ANC_IDX_TAG_SHIFT_HI    16'h280e
`define ANC_IDX_ADJUST_MODE     16'h280f
`define ANC_IDX_SLEW_LIMIT_B0   16'h2810
`define ANC_IDX_SLEW_LIMIT_B1   16'h2811

// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define ANC_BIT_DELTA_TYPE      0
`define ANC_BIT_CYCLE_TYPE      1
`define ANC_RST_BYTE            8'h00
`define ANC_READ_UNMAPPED       32'h0000_0000
`define ANC_OFFS_INT_BITS       8
`define ANC_OFFS_FRAC_BITS      24
`define ANC_SLEW_FRAC_BITS      36

`endif

// ===== verilog/anc_pkg.sv
// Types shared by the auxiliary NCO configuration bank.
`default_nettype none
package anc_pkg;
  typedef enum logic [2:0] {
    ANC_IDLE  = 3'b001,
    ANC_COUNT = 3'b010,
    ANC_TAG   = 3'b100
  } anc_tag_state_t;
  typedef logic [15:0] anc_ratio_t;
endpackage
`default_nettype wire

// ===== verilog/anc_tag_gen.sv
// Tag marker for time stamps, driven by the tag spacing value.
`timescale 1ns/1ns
`default_nettype none
module anc_tag_gen #(
  parameter int RW = 16
) (
  input  wire logic              clk_sys_i,
  input  wire logic              rst_i,
  input  wire logic [RW-1:0]     ratio_i,
  input  wire logic              stamp_i,
  output logic                   tag_o
);
  import anc_pkg::*;

  anc_tag_state_t state;
  anc_tag_state_t next_state;
  logic [RW-1:0]  cnt;
  logic [RW-1:0]  next_cnt;

  // The count restarts after each tag, so every (N+1)th stamp is marked.
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    case (state)
      ANC_IDLE: begin
        next_cnt = '0;
        if (ratio_i != '0) begin
          next_state = ANC_COUNT;
        end
      end
      ANC_COUNT, ANC_TAG: begin
        next_state = ANC_COUNT;
        if (ratio_i == '0) begin
          next_state = ANC_IDLE;
          next_cnt   = '0;
        end else if (stamp_i) begin
          if (cnt >= ratio_i) begin
            next_cnt   = '0;
            next_state = ANC_TAG;
          end else begin
            next_cnt = cnt + 1'b1;
          end
        end
      end
      default: begin
        next_state = ANC_IDLE;
        next_cnt   = '0;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ANC_IDLE;
      cnt   <= '0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  assign tag_o = (state == ANC_TAG);

  tag_every_n_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (state == ANC_COUNT && stamp_i && ratio_i != '0 && cnt >= ratio_i) |=> tag_o)
    else $error("Tag missed at ratio count.");
  tag_off_zero_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (ratio_i == '0) [*2] |-> !tag_o)
    else $error("Tag raised while ratio is zero.");
endmodule
`default_nettype wire
